// ==== hdl/dac_pkg.sv ====
// package: shared constants and types for the dual converter output coder
package dac_pkg;
    // word layout
    localparam int WORD_W = 10;
    localparam int SAMPLE_W = 12; // signed input sample, wider than the word to show overrange
    // output codes
    localparam logic [9:0] CODE_FULL_POS = 10'h3FF;
    localparam logic [9:0] CODE_MID = 10'h200;
    localparam logic [9:0] CODE_FULL_NEG = 10'h000;
    localparam logic [9:0] MSB_FLIP = 10'h200;
    // signed limits of the in-range sample
    localparam logic signed [11:0] SAMPLE_MAX = 12'sh1FF;
    localparam logic signed [11:0] SAMPLE_MIN = -12'sh200;
    // pipeline and stabilizer timing, in sample clock cycles
    localparam int PIPE_DEPTH = 5;
    localparam int RELOCK_CYCLES = 100;
    localparam logic [6:0] RELOCK_CNT_W7 = 7'h64;
    // idle detection: clock-enable low this many cycles counts as stopped clock
    localparam int IDLE_CYCLES = 64;
    localparam logic [6:0] IDLE_CNT_W7 = 7'h40;
    // conversion rate window, kept by the clock source
    localparam int RATE_MAX_SPS = 105000000;
    localparam int RATE_MIN_SPS = 1000000;
    localparam int SKEW_MAX_PS = 1000;
    // configuration level, four decoded strap levels
    typedef enum logic [1:0] {LVL_GND, LVL_THIRD, LVL_TWO_THIRD, LVL_SUPPLY} dac_level_t;
    // range strap: supply rail or common mode output
    typedef enum logic {RANGE_WIDE, RANGE_NARROW} dac_range_t;
    // stabilizer lock state
    typedef enum logic [1:0] {ST_OFF, ST_RELOCK, ST_LOCKED} dac_lock_t;
endpackage : dac_pkg

// ==== hdl/dac_link_if.sv ====
// interface: two-channel parallel output link between converter and capture logic
`timescale 1ns/100ps
`default_nettype none
interface dac_link_if;
    import dac_pkg::*;
    // per-channel sample strobes from the clock source
    logic sampleClockA;
    logic sampleClockB;
    // configuration straps
    dac_level_t modeLevel;
    dac_range_t rangeSelectA;
    dac_range_t rangeSelectB;
    // per-channel outputs
    logic [WORD_W-1:0] conversionWordA;
    logic [WORD_W-1:0] conversionWordB;
    logic overrangeFlagA;
    logic overrangeFlagB;
    logic dataValidA;
    logic dataValidB;
    modport device (
        input sampleClockA, sampleClockB, modeLevel, rangeSelectA, rangeSelectB,
        output conversionWordA, conversionWordB, overrangeFlagA, overrangeFlagB,
        output dataValidA, dataValidB
    );
    modport capture (
        output sampleClockA, sampleClockB, modeLevel, rangeSelectA, rangeSelectB,
        input conversionWordA, conversionWordB, overrangeFlagA, overrangeFlagB,
        input dataValidA, dataValidB
    );
endinterface : dac_link_if
`default_nettype wire

// ==== hdl/dac_device.sv ====
// device end: per-channel coding pipeline with stabilizer lock model
`timescale 1ns/100ps
`default_nettype none
module dac_device #(
    parameter int PIPE = dac_pkg::PIPE_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEnable,
    // analog samples as signed numbers, full span scale
    input wire logic signed [dac_pkg::SAMPLE_W-1:0] sampleInA,
    input wire logic signed [dac_pkg::SAMPLE_W-1:0] sampleInB,
    // stabilizer status
    output logic stabilizerOn,
    output logic stabilizerLocked,
    // link
    dac_link_if.device link
);
    import dac_pkg::*;

    // one register takes the sample and PIPE more carry it, so latency is PIPE + 1 strobes counting the taking one
    localparam int STAGES = PIPE + 1;

    // elaboration checks: no empty pipe, and the sample must be wider than the word
    if (PIPE < 1) begin : g_bad_pipe
        $error("pipeline depth must be at least one");
    end
    if (SAMPLE_W <= WORD_W) begin : g_bad_width
        $error("sample must be wider than the word to show overrange");
    end

    ////////////////////////////////////////////////////////////////////////////
    // stabilizer lock state
    dac_lock_t lock_q, lock_d;
    logic [6:0] cnt_q, cnt_d;
    logic [6:0] idle_q, idle_d;
    logic stabEn;
    logic twosComp;

    // mode strap decode: stabilizer and format
    always_comb begin
        stabEn = (link.modeLevel == LVL_THIRD) || (link.modeLevel == LVL_TWO_THIRD);
        twosComp = (link.modeLevel == LVL_TWO_THIRD) || (link.modeLevel == LVL_SUPPLY);
    end

    // relock after a long clock stop; idle counted while enable is low
    always_comb begin
        lock_d = lock_q;
        cnt_d = cnt_q;
        idle_d = idle_q;
        if (!clockEnable) begin
            if (idle_q != IDLE_CNT_W7) idle_d = idle_q + 7'h01;
        end else begin
            idle_d = 7'h00;
        end
        if (!stabEn) begin
            lock_d = ST_OFF;
            cnt_d = 7'h00;
        end else if (!clockEnable && idle_q == IDLE_CNT_W7) begin
            lock_d = ST_RELOCK;
            cnt_d = 7'h00;
        end else if (clockEnable && link.sampleClockA) begin
            unique case (lock_q)
                ST_OFF: begin
                    lock_d = ST_RELOCK;
                    cnt_d = 7'h00;
                end
                ST_RELOCK: begin
                    cnt_d = cnt_q + 7'h01;
                    if (cnt_q == RELOCK_CNT_W7 - 7'h01) lock_d = ST_LOCKED;
                end
                ST_LOCKED: lock_d = ST_LOCKED;
                default: lock_d = ST_OFF;
            endcase
        end
    end

    // idle counter runs regardless of enable so a stopped clock is seen
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_q <= ST_OFF;
            cnt_q <= 7'h00;
            idle_q <= 7'h00;
        end else begin
            idle_q <= idle_d;
            lock_q <= lock_d;
            cnt_q <= cnt_d;
        end
    end

    // status straight from the strap decode and the lock register
    assign stabilizerOn = stabEn;
    assign stabilizerLocked = (lock_q == ST_LOCKED);

    ////////////////////////////////////////////////////////////////////////////
    // per-channel coding pipeline
    logic [1:0] strobe;
    logic signed [SAMPLE_W-1:0] sampleIn [2];
    dac_range_t rangeSel [2];
    logic [WORD_W-1:0] wordOut [2];
    logic flagOut [2];
    logic validOut [2];

    always_comb begin
        strobe = {link.sampleClockB, link.sampleClockA};
        sampleIn[0] = sampleInA;
        sampleIn[1] = sampleInB;
        rangeSel[0] = link.rangeSelectA;
        rangeSel[1] = link.rangeSelectB;
    end

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic [WORD_W-1:0] pw_q [STAGES];
        logic [WORD_W-1:0] pw_d [STAGES];
        logic pf_q [STAGES];
        logic pf_d [STAGES];
        logic pv_q [STAGES];
        logic pv_d [STAGES];
        logic signed [SAMPLE_W:0] scaled; // one spare bit so doubling cannot wrap
        logic [WORD_W-1:0] code;
        logic over;

        // span scaling, clamp and format
        always_comb begin
            // narrow span doubles the sample; the spare bit keeps the sign of large inputs
            if (rangeSel[ch] == RANGE_NARROW) begin
                scaled = {sampleIn[ch], 1'b0};
            end else begin
                scaled = {sampleIn[ch][SAMPLE_W-1], sampleIn[ch]};
            end
            over = 1'b0;
            if (scaled > SAMPLE_MAX) begin
                code = CODE_FULL_POS;
                over = 1'b1;
            end else if (scaled < SAMPLE_MIN) begin
                code = CODE_FULL_NEG;
                over = 1'b1;
            end else begin
                code = WORD_W'(scaled) ^ CODE_MID;
            end
            if (twosComp) code = code ^ MSB_FLIP;
        end

        // sample stage plus five carry stages, advanced on each clock that the sample strobe is high
        always_comb begin
            for (int i = 0; i < STAGES; i++) begin
                pw_d[i] = pw_q[i];
                pf_d[i] = pf_q[i];
                pv_d[i] = pv_q[i];
            end
            // the pipe advances on every clock the strobe is high, so only a one-clock strobe stands for one edge
            if (clockEnable && strobe[ch]) begin
                pw_d[0] = code;
                pf_d[0] = over;
                pv_d[0] = 1'b1;
                for (int i = 1; i < STAGES; i++) begin
                    pw_d[i] = pw_q[i-1];
                    pf_d[i] = pf_q[i-1];
                    pv_d[i] = pv_q[i-1];
                end
            end
        end

        // pipeline registers; held between strobes by the next-value logic
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                for (int i = 0; i < STAGES; i++) begin
                    pw_q[i] <= '0;
                    pf_q[i] <= 1'b0;
                    pv_q[i] <= 1'b0;
                end
            end else begin
                pw_q <= pw_d;
                pf_q <= pf_d;
                pv_q <= pv_d;
            end
        end

        assign wordOut[ch] = pw_q[STAGES-1];
        assign flagOut[ch] = pf_q[STAGES-1];
        assign validOut[ch] = pv_q[STAGES-1];
    end

    // outputs straight from the last pipeline flops
    assign link.conversionWordA = wordOut[0];
    assign link.conversionWordB = wordOut[1];
    assign link.overrangeFlagA = flagOut[0];
    assign link.overrangeFlagB = flagOut[1];
    assign link.dataValidA = validOut[0];
    assign link.dataValidB = validOut[1];
endmodule : dac_device
`default_nettype wire

// ==== hdl/dac_capture.sv ====
// capture end: sample strobe source, straps, and word capture
`timescale 1ns/100ps
`default_nettype none
module dac_capture #(
    parameter int DIV = 2 // clock cycles per sample; 200 MHz / 2 = 100 Msps
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clockEnable,
    // user configuration
    input wire dac_pkg::dac_level_t modeSel,
    input wire dac_pkg::dac_range_t rangeA,
    input wire dac_pkg::dac_range_t rangeB,
    // captured data
    output logic [dac_pkg::WORD_W-1:0] wordA,
    output logic [dac_pkg::WORD_W-1:0] wordB,
    output logic overA,
    output logic overB,
    output logic wordStrobe,
    // link
    dac_link_if.capture link
);
    import dac_pkg::*;

    // rate window: 200 MHz / DIV must lie in 1..105 Msps
    if (DIV < 2 || DIV > 200) begin : g_bad_div
        $error("divider outside conversion rate window");
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample strobe divider; one source for both channels, zero skew
    logic [7:0] div_q, div_d;
    logic tick;

    always_comb begin
        tick = (div_q == 8'(DIV - 1));
        div_d = tick ? 8'h00 : div_q + 8'h01;
        if (!clockEnable) div_d = div_q;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) div_q <= 8'h00;
        else div_q <= div_d;
    end

    assign link.sampleClockA = clockEnable && tick;
    assign link.sampleClockB = clockEnable && tick;
    assign link.modeLevel = modeSel;
    assign link.rangeSelectA = rangeA;
    assign link.rangeSelectB = rangeB;

    ////////////////////////////////////////////////////////////////////////////
    // capture registers, loaded on each strobe with valid data
    logic [WORD_W-1:0] wa_d, wb_d;
    logic oa_d, ob_d, st_d;

    always_comb begin
        wa_d = wordA;
        wb_d = wordB;
        oa_d = overA;
        ob_d = overB;
        st_d = 1'b0;
        if (clockEnable && tick && link.dataValidA && link.dataValidB) begin
            wa_d = link.conversionWordA;
            wb_d = link.conversionWordB;
            oa_d = link.overrangeFlagA;
            ob_d = link.overrangeFlagB;
            st_d = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wordA <= '0;
            wordB <= '0;
            overA <= 1'b0;
            overB <= 1'b0;
            wordStrobe <= 1'b0;
        end else begin
            wordA <= wa_d;
            wordB <= wb_d;
            overA <= oa_d;
            overB <= ob_d;
            wordStrobe <= st_d;
        end
    end
endmodule : dac_capture
`default_nettype wire

// ==== verif/dac_link_monitor.sv ====
// checker: timing and coding relations on the two-channel link
`timescale 1ns/100ps
`default_nettype none
module dac_link_monitor (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // link
    input wire logic sampleClockA,
    input wire logic sampleClockB,
    input wire dac_pkg::dac_level_t modeLevel,
    input wire logic [dac_pkg::WORD_W-1:0] conversionWordA,
    input wire logic [dac_pkg::WORD_W-1:0] conversionWordB,
    input wire logic overrangeFlagA,
    input wire logic overrangeFlagB,
    input wire logic dataValidA
);
    import dac_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // strobes since reset; saturates so long runs cannot wrap into a false low
    logic [3:0] strobeCnt_q, strobeCnt_d;
    always_comb begin
        strobeCnt_d = strobeCnt_q;
        if (sampleClockA && strobeCnt_q != 4'hF) strobeCnt_d = strobeCnt_q + 4'h1;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) strobeCnt_q <= 4'h0;
        else strobeCnt_q <= strobeCnt_d;
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_offBin;
        modeLevel inside {LVL_GND, LVL_THIRD};
    endsequence
    property p_holdA;
        !sampleClockA |=> $stable(conversionWordA) && $stable(overrangeFlagA);
    endproperty
    property p_holdB;
        !sampleClockB |=> $stable(conversionWordB) && $stable(overrangeFlagB);
    endproperty
    property p_fill;
        $rose(dataValidA) |-> strobeCnt_q >= 4'h5;
    endproperty
    property p_validStays;
        dataValidA |=> dataValidA;
    endproperty
    property p_clampObA;
        s_offBin ##0 overrangeFlagA |-> conversionWordA inside {CODE_FULL_POS, CODE_FULL_NEG};
    endproperty
    property p_clampObB;
        s_offBin ##0 overrangeFlagB |-> conversionWordB inside {CODE_FULL_POS, CODE_FULL_NEG};
    endproperty
    property p_clampTcA;
        !(modeLevel inside {LVL_GND, LVL_THIRD}) && overrangeFlagA
            |-> conversionWordA inside {10'h01FF, 10'h0200};
    endproperty
    property p_clampTcB;
        !(modeLevel inside {LVL_GND, LVL_THIRD}) && overrangeFlagB
            |-> conversionWordB inside {10'h01FF, 10'h0200};
    endproperty
    a_holdA: assert property (p_holdA) else $error("word A moved without strobe");
    a_holdB: assert property (p_holdB) else $error("word B moved without strobe");
    a_fill: assert property (p_fill) else $error("valid before pipeline filled");
    a_validStays: assert property (p_validStays) else $error("valid dropped");
    a_clampObA: assert property (p_clampObA) else $error("A offset clamp wrong");
    a_clampObB: assert property (p_clampObB) else $error("B offset clamp wrong");
    a_clampTcA: assert property (p_clampTcA) else $error("A twos clamp wrong");
    a_clampTcB: assert property (p_clampTcB) else $error("B twos clamp wrong");
endmodule : dac_link_monitor
`default_nettype wire

// ==== verif/tb.sv ====
// testbench: both link ends joined, coding, latency and stabilizer checks
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dac_pkg::*;
    logic clock, rst, clockEnable, overA, overB, wordStrobe, stabOn, stabLocked;
    logic signed [SAMPLE_W-1:0] inA, inB;
    dac_level_t modeSel;
    dac_range_t rangeA, rangeB;
    logic [WORD_W-1:0] wordA, wordB;
    int mismatches, n_compared;
    dac_link_if link ();
    dac_device dac_device_inst (.clock(clock), .rst(rst), .clockEnable(clockEnable),
        .sampleInA(inA), .sampleInB(inB), .stabilizerOn(stabOn),
        .stabilizerLocked(stabLocked), .link(link.device));
    dac_capture dac_capture_inst (.clock(clock), .rst(rst), .clockEnable(clockEnable),
        .modeSel(modeSel), .rangeA(rangeA), .rangeB(rangeB), .wordA(wordA), .wordB(wordB),
        .overA(overA), .overB(overB), .wordStrobe(wordStrobe), .link(link.capture));
    dac_link_monitor dac_link_monitor_inst (.clock(clock), .rst(rst),
        .sampleClockA(link.sampleClockA), .sampleClockB(link.sampleClockB),
        .modeLevel(link.modeLevel), .conversionWordA(link.conversionWordA),
        .conversionWordB(link.conversionWordB), .overrangeFlagA(link.overrangeFlagA),
        .overrangeFlagB(link.overrangeFlagB), .dataValidA(link.dataValidA));
    ////////////////////////////////////////////////////////////////////////////////
    // 200 MHz system clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // a wait that runs out counts as a mismatch and ends the run
    task automatic fail_wait();
        mismatches++;
        $display("Error at %0t: wait ran out", $time);
        close_out();
    endtask : fail_wait
    // inputs move 1 ns after the edge, clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    // the mode strap is a level, so it is set before reset lets go
    task automatic restart(input dac_level_t m);
        modeSel = m;
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
    endtask : restart
    // expected code: span, clamp, then msb flip for offset binary
    function automatic logic [10:0] code(input int x, input dac_range_t r, input dac_level_t m);
        logic [9:0] w;
        logic o;
        if (r == RANGE_NARROW) x = x * 2;
        o = x > 511 || x < -512;
        x = x > 511 ? 511 : (x < -512 ? -512 : x);
        w = x[9:0];
        if (m inside {LVL_GND, LVL_THIRD}) w = w ^ MSB_FLIP;
        return {o, w};
    endfunction : code
    ////////////////////////////////////////////////////////////////////////////////
    // every format level, channels on opposite spans, extremes and overrange
    task automatic testCodes();
        int vals[7] = '{511, 0, -512, 600, -600, 1, -1};
        int k;
        for (int m = 0; m < 4; m++) begin
            restart(dac_level_t'(m));
            foreach (vals[i]) begin
                rangeA = dac_range_t'(i % 2);
                rangeB = dac_range_t'(1 - i % 2);
                inA = 12'(vals[i]);
                inB = 12'(-vals[i]);
                tick(20);
                for (k = 0; k < 50 && wordStrobe !== 1'b1; k++) tick(1);
                if (wordStrobe !== 1'b1) fail_wait();
                chk({overA, wordA}, code(vals[i], rangeA, dac_level_t'(m)));
                chk({overB, wordB}, code(-vals[i], rangeB, dac_level_t'(m)));
            end
        end
        $display("codes test done");
    endtask : testCodes
    // strobes counted from the taking edge until the link word moves
    task automatic testLatency();
        int n, k;
        logic [9:0] old;
        restart(LVL_GND);
        rangeA = RANGE_WIDE;
        inA = 12'h000;
        tick(30);
        for (k = 0; k < 10 && link.sampleClockA !== 1'b1; k++) tick(1);
        if (link.sampleClockA !== 1'b1) fail_wait();
        tick(1);
        old = link.conversionWordA;
        inA = 12'h064;
        n = 0;
        for (k = 0; k < 40 && link.conversionWordA === old; k++) begin
            if (link.sampleClockA === 1'b1) n++;
            tick(1);
        end
        if (link.conversionWordA === old) fail_wait();
        chk(11'(n), 11'(PIPE_DEPTH + 1));
        $display("latency test done");
    endtask : testLatency
    // strobes until lock; no lock within 400 clocks fails the run
    task automatic lockCount(output int n);
        n = 0;
        for (int k = 0; k < 400 && stabLocked !== 1'b1; k++) begin
            if (link.sampleClockA === 1'b1) n++;
            tick(1);
        end
        if (stabLocked !== 1'b1) fail_wait();
    endtask : lockCount
    task automatic testStab();
        int n;
        logic on;
        for (int m = 0; m < 4; m++) begin
            on = m == 1 || m == 2;
            restart(dac_level_t'(m));
            chk(11'(stabOn), 11'(on));
            if (!on) begin
                tick(300);
                chk(11'(stabLocked), 11'h000);
            end else begin
                lockCount(n);
                chk(11'(stabLocked), 11'h001);
                chk(11'(n inside {100, 101}), 11'h001);
                clockEnable = 1'b0;
                tick(70);
                chk(11'(stabLocked), 11'h000);
                clockEnable = 1'b1;
                lockCount(n);
                chk(11'(n inside {100, 101}), 11'h001);
            end
        end
        $display("stabilizer test done");
    endtask : testStab
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mismatches = 0;
        n_compared = 0;
        rst = 1'b1;
        clockEnable = 1'b1;
        inA = '0;
        inB = '0;
        modeSel = LVL_GND;
        rangeA = RANGE_WIDE;
        rangeB = RANGE_WIDE;
        testCodes();
        testLatency();
        testStab();
        close_out();
    end
endmodule : tb
`default_nettype wire
